// >>> dv/smi_sci_sleep_event_logic_test.sv
// Bench for the SMI, SCI and sleep event block
`timescale 1ns/1ns
module smi_sci_sleep_event_logic_test;
	import ssel_pkg::*;

	logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr, rdErr, smiVwMsg;
	logic        powerButtonInN, thermalTripInN, batteryLowInN, rtcAlarmIn, pcieMsgRx, flashWriteTry;
	logic        sleep3OutN, sleep4OutN, sleep5OutN;
	logic [7:0]  paddr, smiCount, n;
	logic [31:0] pwdata, prdata, rdData;
	logic [23:0] sciLines;
	logic [2:0]  expSlp [3:5];
	int          miscompares, checks;
	wire  [2:0]  slp = {sleep5OutN, sleep4OutN, sleep3OutN};

	ssel_top #(.TMR_OVF_CYCLES(28'h40), .BTN_OVR_CYCLES(28'h20)) u_dut (
		.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.powerButtonInN(powerButtonInN), .thermalTripInN(thermalTripInN), .batteryLowInN(batteryLowInN),
		.rtcAlarmIn(rtcAlarmIn), .pcieMsgRx(pcieMsgRx), .flashWriteTry(flashWriteTry),
		.smiVwMsg(smiVwMsg), .sciLines(sciLines), .sleep3OutN(sleep3OutN),
		.sleep4OutN(sleep4OutN), .sleep5OutN(sleep5OutN));

	ssel_host_model u_host (.core_clk(core_clk), .rst_n(rst_n), .smiVwMsg(smiVwMsg), .smiCount(smiCount));

	////////////////////////////////////////////////////////////////////////
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	task end_of_test();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task wt(input int k);
		repeat (k) @(posedge core_clk);
	endtask

	// Request held until pready is seen high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rdData = prdata;
		rdErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
		apb(1'b0, a, 32'h0);
		check(rdData & m, e);
	endtask

	task press();
		powerButtonInN <= 1'b0;
		wt(6);
		powerButtonInN <= 1'b1;
	endtask

	task pme();
		pcieMsgRx <= 1'b1;
		@(posedge core_clk) pcieMsgRx <= 1'b0;
	endtask

	task done(input string s);
		$display("test %s finished", s);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	// Run needs under a thousand cycles
	initial begin
		repeat (5000) @(posedge core_clk);
		miscompares++;
		end_of_test();
	end

	initial begin
		expSlp = '{SLP_OUT_S3, SLP_OUT_S4, SLP_OUT_S5};
		{psel, penable, pwrite, pcieMsgRx, flashWriteTry, rtcAlarmIn, rst_n} = '0;
		{powerButtonInN, thermalTripInN, batteryLowInN} = 3'h7;
		paddr = 8'h00;
		pwdata = 32'h0;
		wt(3);
		rst_n <= 1'b1;
		rd(OFF_CTRL, 32'h00090001);
		rd(OFF_STS, 32'h0, 32'h3fd);
		rd(OFF_EN, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		check(rdErr, 32'h1);
		done("reset");
		apb(1'b1, OFF_EN, 32'h11);
		apb(1'b1, OFF_CTRL, 32'h00090003);
		n = smiCount;
		apb(1'b1, OFF_PMCMD, 32'h5a);
		wt(4);
		check(smiCount, n + 8'h1);
		rd(OFF_CTRL, 32'h00090002);
		rd(OFF_STS, 32'h1, 32'h1);
		wt(8);
		check(smiCount, n + 8'h1);
		apb(1'b1, OFF_CTRL, 32'h00090003);
		wt(4);
		check(smiCount, n + 8'h2);
		apb(1'b1, OFF_STS, 32'h1);
		rd(OFF_STS, 32'h0, 32'h1);
		apb(1'b1, OFF_CTRL, 32'h00090003);
		flashWriteTry <= 1'b1;
		@(posedge core_clk) flashWriteTry <= 1'b0;
		wt(4);
		check(smiCount, n + 8'h3);
		apb(1'b1, OFF_STS, 32'h10);
		apb(1'b1, OFF_CTRL, 32'h00090203);
		apb(1'b1, OFF_CTRL, 32'h00090303);
		wt(4);
		check(smiCount, n + 8'h4);
		apb(1'b1, OFF_STS, 32'h10);
		apb(1'b1, OFF_CTRL, 32'h00090001);
		apb(1'b1, OFF_PMCMD, 32'h33);
		wt(8);
		check(smiCount, n + 8'h4);
		apb(1'b1, OFF_CTRL, 32'h00090003);
		wt(4);
		check(smiCount, n + 8'h5);
		apb(1'b1, OFF_STS, 32'h3ff);
		done("smi");
		apb(1'b1, OFF_EN, 32'h2);
		apb(1'b1, OFF_STS, 32'h2);
		n = smiCount;
		apb(1'b1, OFF_CTRL, 32'h00090003);
		wt(66);
		check(smiCount, n + 8'h1);
		rd(OFF_STS, 32'h2, 32'h2);
		apb(1'b1, OFF_EN, 32'h88);
		apb(1'b1, OFF_CTRL, 32'h000a0005);
		pme();
		wt(3);
		check(sciLines, 24'h000400);
		wt(8);
		check(sciLines, 24'h000400);
		apb(1'b1, OFF_STS, 32'h8);
		wt(3);
		check(sciLines, 24'h0);
		apb(1'b1, OFF_CTRL, 32'h00140405);
		pme();
		wt(3);
		check(sciLines, 24'h100000);
		apb(1'b1, OFF_CTRL, 32'h00140c05);
		wt(3);
		check(sciLines, 24'h0);
		apb(1'b1, OFF_STS, 32'h8);
		wt(3);
		check(sciLines, 24'h100000);
		apb(1'b1, OFF_CTRL, 32'h00090009);
		wt(3);
		check(sciLines, 24'h000200);
		apb(1'b1, OFF_STS, 32'h3ff);
		done("sci");
		apb(1'b1, OFF_EN, 32'h20);
		n = smiCount;
		apb(1'b1, OFF_CTRL, 32'h00090073);
		wt(4);
		check(smiCount, n + 8'h1);
		check(slp, SLP_OUT_S0);
		rd(OFF_STS, 32'h20, 32'h20);
		apb(1'b1, OFF_EN, 32'h0);
		apb(1'b1, OFF_STS, 32'h3ff);
		for (int t = 3; t <= 5; t++) begin
			apb(1'b1, OFF_CTRL, 32'h00090010 | (32'(t) << 5));
			wt(3);
			check(slp, expSlp[t]);
			press();
			wt(6);
			check(slp, SLP_OUT_S0);
			rd(OFF_STS, 32'h40, 32'h40);
			apb(1'b1, OFF_STS, 32'h3ff);
		end
		apb(1'b1, OFF_CTRL, 32'h00090070);
		batteryLowInN <= 1'b0;
		press();
		wt(10);
		check(slp, SLP_OUT_S3);
		batteryLowInN <= 1'b1;
		wt(10);
		check(slp, SLP_OUT_S0);
		apb(1'b1, OFF_EN, 32'h200);
		apb(1'b1, OFF_CTRL, 32'h00090070);
		wt(3);
		rtcAlarmIn <= 1'b1;
		wt(8);
		check(slp, SLP_OUT_S0);
		rtcAlarmIn <= 1'b0;
		apb(1'b1, OFF_STS, 32'h3ff);
		done("sleep");
		apb(1'b1, OFF_EN, 32'h204);
		apb(1'b1, OFF_CTRL, 32'h00090005);
		thermalTripInN <= 1'b0;
		wt(8);
		check(slp, SLP_OUT_S5);
		thermalTripInN <= 1'b1;
		check(sciLines, 24'h0);
		rtcAlarmIn <= 1'b1;
		wt(8);
		check(slp, SLP_OUT_S5);
		rtcAlarmIn <= 1'b0;
		press();
		wt(6);
		check(slp, SLP_OUT_S0);
		check(sciLines, 24'h000200);
		apb(1'b1, OFF_STS, 32'h3ff);
		wt(3);
		check(sciLines, 24'h0);
		powerButtonInN <= 1'b0;
		wt(45);
		powerButtonInN <= 1'b1;
		wt(2);
		check(slp, SLP_OUT_S5);
		check(sciLines, 24'h0);
		rd(OFF_STS, 32'h4, 32'h4);
		press();
		wt(6);
		check(slp, SLP_OUT_S0);
		check(sciLines, 24'h000200);
		done("override");
		end_of_test();
	end
endmodule

// >>> dv/ssel_host_model.sv
// Host processor model that counts SMI messages
`timescale 1ns/1ns
module ssel_host_model (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        smiVwMsg,
	output logic      [7:0]  smiCount
);
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			smiCount <= 8'h00;
		else if (smiVwMsg)
			smiCount <= smiCount + 8'h01;
	end
endmodule

// >>> hw/ssel_pkg.sv
// Constants, register map and types of the SMI/SCI and sleep event block
// Function
// - Enabled SMI event with re-arm bit set clears the bit and sends SMI.
// - SMI goes to the processor as a virtual wire message, not a pin.
// - After an SMI, events wait for software re-arm; re-arm resends if still active.
// - SCI is a level held while any enabled SCI source stays active; the code raises PME and override SCI only with SCI-select 1.
// - SCI routable to lines 9-11, or 20-23 in APIC mode; sharing sets polarity.
// - Every SMI or SCI source has its own status bit and enable bit.
// - Dual events go to SCI when SCI-select is 1, to SMI when 0.
// - No SMI at all unless the global SMI enable is 1.
// - Firmware-release write sets global-release status; it raises SCI regardless of SCI-select.
// - Power-management command port write sets its status and raises SMI if enabled.
// - PM timer overflow every 2.34 s sets status and raises SCI or SMI.
// - Button override goes to S5, sets status; its SCI only after wake to S0.
// - PCIe PME message sets PME status; with enable it raises SCI; the code raises that SCI only when SCI-select is 1.
// - Flash write while protected, or unprotect rising while locked, sets status and SMI.
// - Sleep-go write with SMI-on-sleep enabled raises SMI and sets status.
// - Software prepares, writes sleep type, sets sleep-go; device enters that state.
// - Power button held over 4 s causes override and move to S5.
// - Thermal trip asserted in S0 forces S5.
// - Sleep outputs are cumulative: S3; S3+S4; S3+S4+S5.
// - Wake from a sleep state sets wake status and returns to S0.
// - Battery low blocks wake; wake events are latched and served on release.
// - RTC alarm wakes when enabled, not after reset-type shutdown; button always wakes.
package ssel_pkg;

	typedef enum logic [1:0] {SSEL_S0, SSEL_S3, SSEL_S4, SSEL_S5} ssel_state_t;

	////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL  = 8'h00;
	localparam logic [7:0] OFF_STS   = 8'h04;
	localparam logic [7:0] OFF_EN    = 8'h08;
	localparam logic [7:0] OFF_PMCMD = 8'h0c;
	localparam logic [7:0] OFF_STATE = 8'h10;

	// Control fields
	localparam int C_REARM   = 0;
	localparam int C_GSMI    = 1;
	localparam int C_SCISEL  = 2;
	localparam int C_FWREL   = 3;
	localparam int C_SLPGO   = 4;
	localparam int C_STYP    = 5;
	localparam int C_WUNPROT = 8;
	localparam int C_FLOCK   = 9;
	localparam int C_APIC    = 10;
	localparam int C_SHARED  = 11;
	localparam int C_ROUTE   = 16;
	localparam logic REARM_RST = 1'b1;

	localparam logic [2:0] STYP_S3 = 3'h3;
	localparam logic [2:0] STYP_S4 = 3'h4;
	localparam logic [2:0] STYP_S5 = 3'h5;

	// Status and enable bit positions
	localparam int NSTS      = 10;
	localparam int ST_PMCMD  = 0;
	localparam int ST_TMROVF = 1;
	localparam int ST_BTNOVR = 2;
	localparam int ST_PME    = 3;
	localparam int ST_FLASH  = 4;
	localparam int ST_SLPSMI = 5;
	localparam int ST_WAKE   = 6;
	localparam int ST_GREL   = 7;
	localparam int ST_PWRBTN = 8;
	localparam int ST_RTC    = 9;
	localparam logic [NSTS-1:0] SMI_ONLY_MASK = 10'h031;
	localparam logic [NSTS-1:0] DUAL_MASK     = 10'h302;
	localparam logic [NSTS-1:0] SCI_ONLY_MASK = 10'h00c;
	localparam logic [NSTS-1:0] STS_RST       = 10'h000;
	localparam logic [NSTS-1:0] EN_RST        = 10'h000;

	// SCI line numbers
	localparam logic [4:0] IRQ_LEG_LO  = 5'h09;
	localparam logic [4:0] IRQ_LEG_HI  = 5'h0b;
	localparam logic [4:0] IRQ_APIC_LO = 5'h14;
	localparam logic [4:0] IRQ_APIC_HI = 5'h17;

	// Sleep outputs {s5N, s4N, s3N}, active low
	localparam logic [2:0] SLP_OUT_S0 = 3'h7;
	localparam logic [2:0] SLP_OUT_S3 = 3'h6;
	localparam logic [2:0] SLP_OUT_S4 = 3'h4;
	localparam logic [2:0] SLP_OUT_S5 = 3'h0;

	// Pin idle levels {rtc, batteryLowN, thermalN, buttonN}
	localparam logic [3:0] PIN_IDLE = 4'h7;

	////////////////////////////////////////////////////////////////////////
	// Timing
	localparam longint CLK_HZ       = 50000000;
	localparam longint TMR_OVF_MS   = 2340;
	localparam longint BTN_OVR_MS   = 4000;
	localparam logic [27:0] TMR_OVF_CYC = 28'(TMR_OVF_MS * CLK_HZ / 1000);
	localparam logic [27:0] BTN_OVR_CYC = 28'(BTN_OVR_MS * CLK_HZ / 1000 + 1);

endpackage

// >>> hw/ssel_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module ssel_sync #(
	parameter int         W    = 4,
	parameter logic [3:0] IDLE = 4'h0
) (
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	logic [W-1:0] ff1_r;
	logic [W-1:0] ff2_r;
	logic [W-1:0] ff3_r;

	// First stage feeds only the second
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ff1_r <= IDLE[W-1:0];
			ff2_r <= IDLE[W-1:0];
			ff3_r <= IDLE[W-1:0];
		end else begin
			ff1_r <= din;
			ff2_r <= ff1_r;
			ff3_r <= ff2_r;
		end
	end

	// A change counts once stages two and three agree
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dout <= IDLE[W-1:0];
		end else begin
			for (int i = 0; i < W; i++) begin
				if (ff2_r[i] == ff3_r[i]) begin
					dout[i] <= ff3_r[i];
				end
			end
		end
	end

endmodule

// >>> hw/ssel_top.sv
// SMI/SCI generation, sleep sequencing and wake logic with APB registers
`timescale 1ns/1ns
module ssel_top
	import ssel_pkg::*;
#(
	parameter logic [27:0] TMR_OVF_CYCLES = ssel_pkg::TMR_OVF_CYC,
	parameter logic [27:0] BTN_OVR_CYCLES = ssel_pkg::BTN_OVR_CYC
) (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        powerButtonInN,
	input  wire logic        thermalTripInN,
	input  wire logic        batteryLowInN,
	input  wire logic        rtcAlarmIn,
	input  wire logic        pcieMsgRx,
	input  wire logic        flashWriteTry,
	output logic             smiVwMsg,
	output logic [23:0]      sciLines,
	output logic             sleep3OutN,
	output logic             sleep4OutN,
	output logic             sleep5OutN
);
	import ssel_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Register state
	logic              rearm_r;
	logic              gsmi_r;
	logic              sciSel_r;
	logic [2:0]        sleepType_r;
	logic              unprot_r;
	logic              lock_r;
	logic              apic_r;
	logic              shared_r;
	logic [4:0]        route_r;
	logic [NSTS-1:0]   sts_r;
	logic [NSTS-1:0]   en_r;
	logic [NSTS-1:0]   stsSet;
	logic [NSTS-1:0]   stsClr;
	logic [7:0]        pmCmd_r;
	ssel_state_t       state_r;
	logic              wakePending_r;
	logic              resetShut_r;
	logic              sciLevel_r;
	logic              smiVw_r;
	logic [23:0]       sciLines_r;
	logic [2:0]        slpOut_r;
	logic [31:0]       prdata_r;
	logic              pready_r;
	logic              pslverr_r;
	logic [26:0]       tmrCnt_r;
	logic [27:0]       btnCnt_r;
	logic              btnHeld_d_r;
	logic              rtc_d_r;
	logic [3:0]        pins;

	function automatic logic anyEvent(input logic [NSTS-1:0] s, input logic [NSTS-1:0] e,
			input logic [NSTS-1:0] m);
		anyEvent = |(s & e & m);
	endfunction

	function automatic logic routeOk(input logic [4:0] r, input logic apic);
		routeOk = (r >= IRQ_LEG_LO && r <= IRQ_LEG_HI) || (apic && r >= IRQ_APIC_LO && r <= IRQ_APIC_HI);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	ssel_sync #(.W(4), .IDLE(PIN_IDLE)) u_sync (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.din      ({rtcAlarmIn, batteryLowInN, thermalTripInN, powerButtonInN}),
		.dout     (pins)
	);

	logic btnHeld;
	logic thermal;
	logic batLow;
	logic rtcAlarm;
	assign btnHeld  = ~pins[0];
	assign thermal  = ~pins[1];
	assign batLow   = ~pins[2];
	assign rtcAlarm = pins[3];

	////////////////////////////////////////////////////////////////////////
	// APB decode; zero wait states
	logic wrAcc;
	logic wrCtrl;
	logic wrSts;
	logic wrEn;
	logic wrCmd;
	logic mapped;
	assign wrAcc  = psel & penable & pwrite;
	assign wrCtrl = wrAcc && paddr == OFF_CTRL;
	assign wrSts  = wrAcc && paddr == OFF_STS;
	assign wrEn   = wrAcc && paddr == OFF_EN;
	assign wrCmd  = wrAcc && paddr == OFF_PMCMD;
	assign mapped = paddr == OFF_CTRL || paddr == OFF_STS || paddr == OFF_EN
		|| paddr == OFF_PMCMD || paddr == OFF_STATE;

	logic [31:0] ctrlRd;
	logic [31:0] stateRd;
	logic [31:0] rdMux;
	always_comb begin
		ctrlRd              = '0;
		ctrlRd[C_REARM]     = rearm_r;
		ctrlRd[C_GSMI]      = gsmi_r;
		ctrlRd[C_SCISEL]    = sciSel_r;
		ctrlRd[C_STYP +: 3] = sleepType_r;
		ctrlRd[C_WUNPROT]   = unprot_r;
		ctrlRd[C_FLOCK]     = lock_r;
		ctrlRd[C_APIC]      = apic_r;
		ctrlRd[C_SHARED]    = shared_r;
		ctrlRd[C_ROUTE +: 5] = route_r;
		stateRd = {26'h0, resetShut_r, wakePending_r, smiVw_r, sciLevel_r, state_r};
		unique case (paddr)
			OFF_CTRL:  rdMux = ctrlRd;
			OFF_STS:   rdMux = {22'h0, sts_r};
			OFF_EN:    rdMux = {22'h0, en_r};
			OFF_PMCMD: rdMux = {24'h0, pmCmd_r};
			OFF_STATE: rdMux = stateRd;
			default:   rdMux = '0;
		endcase
	end

	// Read data and error are captured in the setup phase
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata_r  <= '0;
			pslverr_r <= 1'b0;
			pready_r  <= 1'b0;
		end else begin
			pready_r <= 1'b1;
			if (psel && !penable) begin
				prdata_r  <= pwrite ? 32'h0 : rdMux;
				pslverr_r <= ~mapped;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			gsmi_r      <= 1'b0;
			sciSel_r    <= 1'b0;
			sleepType_r <= '0;
			unprot_r    <= 1'b0;
			lock_r      <= 1'b0;
			apic_r      <= 1'b0;
			shared_r    <= 1'b0;
			route_r     <= IRQ_LEG_LO;
		end else if (wrCtrl) begin
			gsmi_r      <= pwdata[C_GSMI];
			sciSel_r    <= pwdata[C_SCISEL];
			sleepType_r <= pwdata[C_STYP +: 3];
			unprot_r    <= pwdata[C_WUNPROT];
			lock_r      <= pwdata[C_FLOCK];
			apic_r      <= pwdata[C_APIC];
			shared_r    <= pwdata[C_SHARED];
			route_r     <= pwdata[C_ROUTE +: 5];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			en_r    <= EN_RST;
			pmCmd_r <= '0;
		end else begin
			if (wrEn) begin
				en_r <= pwdata[NSTS-1:0];
			end
			if (wrCmd) begin
				pmCmd_r <= pwdata[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Event sources
	logic tmrOvf;
	logic ovrFire;
	logic btnPress;
	logic slpGo;
	logic slpEnter;
	logic wakeFire;
	assign tmrOvf   = tmrCnt_r == 27'(TMR_OVF_CYCLES - 28'h1);
	assign ovrFire  = btnHeld && btnCnt_r == BTN_OVR_CYCLES - 28'h1;
	assign btnPress = btnHeld & ~btnHeld_d_r;
	assign slpGo    = wrCtrl & pwdata[C_SLPGO];
	// Firmware intercept: with SMI-on-sleep armed the write only raises SMI
	assign slpEnter = slpGo & ~en_r[ST_SLPSMI];
	assign wakeFire = state_r != SSEL_S0 && wakePending_r && !batLow;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tmrCnt_r <= '0;
		end else begin
			tmrCnt_r <= tmrOvf ? 27'h0 : tmrCnt_r + 27'h1;
		end
	end

	// hold-time counter; saturates so the override fires once per hold
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			btnCnt_r    <= '0;
			btnHeld_d_r <= 1'b0;
			rtc_d_r     <= 1'b0;
		end else begin
			btnHeld_d_r <= btnHeld;
			rtc_d_r     <= rtcAlarm;
			if (!btnHeld || state_r != SSEL_S0) begin
				btnCnt_r <= '0;
			end else if (btnCnt_r != BTN_OVR_CYCLES) begin
				btnCnt_r <= btnCnt_r + 28'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status bits
	always_comb begin
		stsSet = '0;
		stsSet[ST_PMCMD]  = wrCmd;
		stsSet[ST_TMROVF] = tmrOvf;
		stsSet[ST_BTNOVR] = ovrFire;
		stsSet[ST_PME]    = pcieMsgRx;
		stsSet[ST_FLASH]  = (flashWriteTry & ~unprot_r) | (wrCtrl & pwdata[C_WUNPROT] & ~unprot_r & lock_r);
		stsSet[ST_SLPSMI] = slpGo & en_r[ST_SLPSMI];
		stsSet[ST_WAKE]   = wakeFire;
		stsSet[ST_GREL]   = wrCtrl & pwdata[C_FWREL];
		stsSet[ST_PWRBTN] = btnPress && state_r == SSEL_S0;
		stsSet[ST_RTC]    = rtcAlarm & ~rtc_d_r;
		stsClr = wrSts ? pwdata[NSTS-1:0] : '0;
	end

	// write-one-to-clear, a new event beats the clear
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sts_r <= STS_RST;
		end else begin
			sts_r <= (sts_r & ~stsClr) | stsSet;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// SMI generation
	logic smiActive;
	logic smiFire;
	assign smiActive = gsmi_r & anyEvent(sts_r, en_r, SMI_ONLY_MASK | (sciSel_r ? '0 : DUAL_MASK));
	assign smiFire   = rearm_r & smiActive;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rearm_r <= REARM_RST;
		end else if (smiFire) begin
			rearm_r <= 1'b0;
		end else if (wrCtrl && pwdata[C_REARM]) begin
			rearm_r <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			smiVw_r <= 1'b0;
		end else begin
			smiVw_r <= smiFire;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// SCI generation; held off while asleep, so override status waits for S0
	logic sciActive;
	logic sciPol;
	assign sciActive = state_r == SSEL_S0
		&& ((sciSel_r && anyEvent(sts_r, en_r, DUAL_MASK | SCI_ONLY_MASK)) || (sts_r[ST_GREL] && en_r[ST_GREL]));
	assign sciPol    = sciActive ^ shared_r;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sciLevel_r <= 1'b0;
			sciLines_r <= '0;
		end else begin
			sciLevel_r <= sciActive;
			sciLines_r <= (routeOk(route_r, apic_r) && sciPol) ? 24'h000001 << route_r : 24'h000000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sleep state machine
	// latch wakes, a new wake beats the clear
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wakePending_r <= 1'b0;
		end else if (state_r != SSEL_S0
				&& (btnPress || (rtcAlarm && !rtc_d_r && en_r[ST_RTC] && !resetShut_r))) begin
			wakePending_r <= 1'b1;
		end else if (wakeFire) begin
			wakePending_r <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r     <= SSEL_S0;
			resetShut_r <= 1'b0;
		end else begin
			unique case (state_r)
				SSEL_S0: begin
					if (thermal || ovrFire) begin
						state_r     <= SSEL_S5;
						resetShut_r <= 1'b1;
					end else if (slpEnter) begin
						unique case (pwdata[C_STYP +: 3])
							STYP_S3: state_r <= SSEL_S3;
							STYP_S4: state_r <= SSEL_S4;
							STYP_S5: state_r <= SSEL_S5;
							default: state_r <= SSEL_S0;
						endcase
					end
				end
				SSEL_S3, SSEL_S4, SSEL_S5: begin
					if (wakeFire) begin
						state_r     <= SSEL_S0;
						resetShut_r <= 1'b0;
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			slpOut_r <= SLP_OUT_S0;
		end else begin
			unique case (state_r)
				SSEL_S0: slpOut_r <= SLP_OUT_S0;
				SSEL_S3: slpOut_r <= SLP_OUT_S3;
				SSEL_S4: slpOut_r <= SLP_OUT_S4;
				SSEL_S5: slpOut_r <= SLP_OUT_S5;
			endcase
		end
	end

	assign prdata     = prdata_r;
	assign pready     = pready_r;
	assign pslverr    = pslverr_r;
	assign smiVwMsg   = smiVw_r;
	assign sciLines   = sciLines_r;
	assign sleep3OutN = slpOut_r[0];
	assign sleep4OutN = slpOut_r[1];
	assign sleep5OutN = slpOut_r[2];

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence rearmSet;
		!rearm_r && wrCtrl && pwdata[C_REARM];
	endsequence

	a_smi_rearm_clear: assert property (smiFire |=> !rearm_r && smiVwMsg)
		else $error("SMI sent without clearing re-arm");
	a_smi_no_repeat: assert property (smiVwMsg |-> !smiFire ##1 !smiVwMsg)
		else $error("SMI message repeated while disarmed");
	a_smi_resend: assert property (rearmSet ##1 smiActive |=> smiVwMsg)
		else $error("Re-arm with active event gave no SMI");
	a_smi_global_gate: assert property (!gsmi_r |=> !smiVwMsg)
		else $error("SMI while globally disabled");
	a_sci_level_hold: assert property (state_r == SSEL_S0 && sciSel_r
		&& anyEvent(sts_r, en_r, DUAL_MASK) |=> sciLevel_r)
		else $error("SCI dropped while source active");
	a_sci_global_rel: assert property (state_r == SSEL_S0 && sts_r[ST_GREL] && en_r[ST_GREL] |=> sciLevel_r)
		else $error("Global release gave no SCI");
	a_tmr_ovf_sts: assert property (tmrOvf |=> sts_r[ST_TMROVF])
		else $error("Timer overflow not recorded");
	a_thermal_to_s5: assert property (state_r == SSEL_S0 && thermal
		|=> state_r == SSEL_S5 ##1 slpOut_r == SLP_OUT_S5)
		else $error("Thermal trip did not force S5");
	a_sleep_out_s4: assert property (state_r == SSEL_S4
		|=> sleep3OutN == 1'b0 && sleep4OutN == 1'b0 && sleep5OutN)
		else $error("S4 outputs wrong");
	a_wake_sets_sts: assert property (state_r != SSEL_S0 ##1 state_r == SSEL_S0 |-> sts_r[ST_WAKE])
		else $error("Wake without wake status");
	a_batlow_hold: assert property (state_r != SSEL_S0 && batLow |=> state_r != SSEL_S0)
		else $error("Woke while battery low");

endmodule
